// file: rtl/wdc_ctrl.sv
// host-side controller driving the wide dram pins
`timescale 1ns/1ps
`default_nettype none
`include "wdc_defines.svh"
// Behaviour
// R1 - write strobe low before column strobe gives early write, pins float
// R2 - write strobe late after delays gives late write after cell read
// R3 - never trust data pins when write timing is neither early nor late
// R4 - output enable high, write after column strobe: late write
// R5 - write data held from column strobe (early) or write strobe (late)
// R6 - output enable must be driven, never tied low, for late writes
// R7 - hidden refresh after write: column low, row cycled, write low, oe high
// R8 - write command is either lane strobe low, or the single strobe
// R9 - output enable high during late write so device outputs open
// R10 - read data pins float after output enable or column strobe rise
// R11 - write strobe at row strobe fall selects masked or normal write
// R12 - byte variant ignores strobes and data at row strobe fall
// R13 - internal write spans first lane strobe fall to last rise
// R14 - lower strobe writes low byte, upper strobe writes high byte
// R15 - oe only matters with row and column low and writes high
// R16 - unwritten lane stays high impedance on device side
// R17 - row half on row strobe fall, column half on column strobe fall
// R18 - reads return all sixteen data bits
// R19 - column strobe fall samples write data
// R20 - refresh all 256 rows within 32 ms, one each 125 us
// R21 - mask bit one writes that bit, zero blocks it
// R22 - fresh mask supplied every masked write cycle
// R23 - page mode keeps row low, pulses column, row rise ends page
// R24 - column-first refresh uses internal row counter, no address
module wdc_ctrl
  import wdc_pkg::*;
(
  input wire logic clk,                  // 25 MHz clock
  input wire logic rstn,                 // async reset, active low
  input wire logic req_valid,            // access request
  output logic req_ready,                // request taken
  input wire wdc_op_type req_op,         // access kind
  input wire logic [15:0] req_addr,      // word address, row in top half
  input wire logic [15:0] req_wdata,     // write data
  input wire logic [1:0] req_lanes,      // byte lanes to write
  input wire logic [15:0] req_mask,      // per-bit write mask
  input wire logic req_page,             // keep row open after access
  output logic rsp_valid,                // read data valid pulse
  output logic [15:0] rsp_rdata,         // read data
  output logic row_strobe_n,             // row strobe, active low
  output logic col_strobe_n,             // column strobe, active low
  output logic low_lane_write_strobe_n,  // lower lane write, active low
  output logic high_lane_write_strobe_n, // upper lane write, active low
  output logic out_enable_n,             // device output enable, low
  output logic [7:0] multiplexed_address_inputs, // shared address pins
  input wire logic [15:0] data_pins_i,   // data pins as seen
  output logic [15:0] data_pins_o,       // data pins driven value
  output logic data_pins_oe              // high while driving data pins
);
  wdc_state_type st_q;
  wdc_op_type op_q;
  logic [15:0] addr_q, wdata_q, mask_q;
  logic [1:0] lanes_q;
  logic page_q, t_load, t_done, ref_due_q, ref_take;
  logic [11:0] t_val, refi_q;
  logic [7:0] row_open_q;
  logic row_open_vld_q;
  wdc_timer #(.W(12)) i_wdc_timer (
    .clk(clk), .rstn(rstn), .load(t_load), .val(t_val), .done(t_done)
  );
  // ----------------------------------------
  // refresh interval timer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      refi_q <= '0;
      ref_due_q <= 1'b0;
    end else begin
      if (refi_q == 12'(`WDC_REFI_CYC - 1)) begin
        refi_q <= '0;
      end else begin
        refi_q <= refi_q + 1'b1;
      end
      if (refi_q == 12'(`WDC_REFI_CYC - 1)) begin
        ref_due_q <= 1'b1; // R20
      end else if (ref_take) begin
        ref_due_q <= 1'b0;
      end
    end
  end
  // refresh goes first when idle; row counter is inside the device
  assign ref_take = (st_q == WDC_IDLE) && ref_due_q; // R24
  assign req_ready = (st_q == WDC_IDLE && !ref_due_q) ||
                     (st_q == WDC_PRECH && page_q && t_done &&
                      !ref_due_q && req_valid && row_open_vld_q &&
                      req_addr[15:`WDC_ROW_LSB] == row_open_q); // R23
  // ----------------------------------------
  // request capture
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_q <= WDC_OP_READ;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      mask_q <= 16'h0000;
      lanes_q <= 2'h0;
      page_q <= 1'b0;
    end else if (req_valid && req_ready) begin
      op_q <= req_op;
      addr_q <= req_addr;
      wdata_q <= req_wdata;
      mask_q <= req_mask; // R22
      lanes_q <= req_lanes;
      page_q <= req_page;
    end
  end
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= WDC_IDLE;
    end else begin
      case (st_q)
        WDC_IDLE: begin
          if (ref_take) begin
            st_q <= WDC_CBR_CAS;
          end else if (req_valid) begin
            st_q <= WDC_ROW;
          end
        end
        WDC_ROW: if (t_done) st_q <= WDC_COL;
        WDC_COL: if (t_done) st_q <= WDC_ACCESS;
        WDC_ACCESS: begin
          if (t_done) begin
            if (op_q == WDC_OP_LATE_WRITE) begin
              st_q <= WDC_WRLATE;
            end else if (op_q == WDC_OP_READ) begin
              st_q <= WDC_OEREAD;
            end else begin
              st_q <= WDC_PRECH;
            end
          end
        end
        WDC_WRLATE: if (t_done) st_q <= WDC_PRECH;
        WDC_OEREAD: st_q <= WDC_PRECH;
        WDC_PRECH: begin
          if (req_ready && req_valid) begin
            st_q <= WDC_COL;
          end else if (t_done) begin
            st_q <= WDC_IDLE;
          end
        end
        WDC_CBR_CAS: if (t_done) st_q <= WDC_CBR_RAS;
        WDC_CBR_RAS: if (t_done) st_q <= WDC_IDLE;
        default: st_q <= WDC_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // phase timer loads on each state entry except entry to idle
  // ----------------------------------------
  always_comb begin
    t_load = 1'b0;
    t_val = 12'h000;
    case (st_q)
      WDC_IDLE: begin
        t_load = ref_take || req_valid;
        t_val = 12'(`WDC_RCD_CYC);
      end
      WDC_ROW: begin
        t_load = t_done;
        t_val = 12'(`WDC_CWD_CYC);
      end
      WDC_COL: begin
        t_load = t_done;
        t_val = 12'(`WDC_CAS_CYC);
      end
      WDC_ACCESS: begin
        t_load = t_done;
        t_val = (op_q == WDC_OP_LATE_WRITE) ? 12'(`WDC_WP_CYC)
                                             : 12'(`WDC_RP_CYC);
      end
      WDC_WRLATE: begin
        t_load = t_done;
        t_val = 12'(`WDC_RP_CYC);
      end
      WDC_OEREAD: begin
        t_load = 1'b1;
        t_val = 12'(`WDC_RP_CYC);
      end
      WDC_PRECH: begin
        t_load = req_ready && req_valid;
        t_val = 12'(`WDC_CWD_CYC);
      end
      WDC_CBR_CAS: begin
        t_load = t_done;
        t_val = 12'(`WDC_RAS_CYC);
      end
      default: t_load = 1'b0;
    endcase
  end
  // ----------------------------------------
  // open row tracking for page mode
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      row_open_q <= 8'h00;
      row_open_vld_q <= 1'b0;
    end else if (st_q == WDC_ROW) begin
      row_open_q <= addr_q[15:`WDC_ROW_LSB];
      row_open_vld_q <= 1'b1;
    end else if (st_q == WDC_IDLE) begin
      row_open_vld_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // strobe pins
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      row_strobe_n <= 1'b1;
      col_strobe_n <= 1'b1;
      low_lane_write_strobe_n <= 1'b1;
      high_lane_write_strobe_n <= 1'b1;
      out_enable_n <= 1'b1;
      multiplexed_address_inputs <= 8'h00;
    end else begin
      // row low from row phase until precharge, and through precharge in page mode; cbr drops column first
      row_strobe_n <= !(st_q == WDC_ROW || st_q == WDC_COL ||
                        st_q == WDC_ACCESS || st_q == WDC_WRLATE ||
                        st_q == WDC_OEREAD || st_q == WDC_CBR_RAS ||
                        (st_q == WDC_PRECH && page_q)); // R23
      col_strobe_n <= !(st_q == WDC_ACCESS || st_q == WDC_WRLATE ||
                        st_q == WDC_OEREAD || st_q == WDC_CBR_CAS ||
                        st_q == WDC_CBR_RAS); // R24
      // row half before row fall, column half before column fall
      multiplexed_address_inputs <= (st_q == WDC_IDLE)
        ? req_addr[15:`WDC_ROW_LSB]
        : (st_q == WDC_ROW) ? addr_q[15:`WDC_ROW_LSB]
        : addr_q[`WDC_ADDR_HALF-1:0]; // R17
      // masked write: both strobes low at row fall; otherwise high
      if (st_q == WDC_IDLE) begin
        low_lane_write_strobe_n <= !(req_valid && !ref_due_q &&
                                     req_op == WDC_OP_MASK_WRITE); // R11
        high_lane_write_strobe_n <= !(req_valid && !ref_due_q &&
                                      req_op == WDC_OP_MASK_WRITE);
      end else if ((st_q == WDC_ROW && op_q != WDC_OP_MASK_WRITE) ||
                   st_q == WDC_PRECH || st_q == WDC_OEREAD ||
                   st_q == WDC_CBR_CAS) begin // R12
        low_lane_write_strobe_n <= 1'b1;
        high_lane_write_strobe_n <= 1'b1;
      end else if ((st_q == WDC_COL && op_q != WDC_OP_READ &&
                    op_q != WDC_OP_LATE_WRITE) ||
                   st_q == WDC_WRLATE) begin
        // early: strobes fall before column strobe; late: after it
        low_lane_write_strobe_n <= !lanes_q[0]; // R1 R8 R13 R14
        high_lane_write_strobe_n <= !lanes_q[1]; // R2 R4 R14 R16
      end
      // oe low through read access and capture; high through late write
      out_enable_n <= !((st_q == WDC_ACCESS || st_q == WDC_OEREAD) &&
                        op_q == WDC_OP_READ); // R6 R9 R15
    end
  end
  // ----------------------------------------
  // data pins: mask at row fall, write data until strobe release
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_pins_o <= 16'h0000;
      data_pins_oe <= 1'b0;
    end else if (st_q == WDC_IDLE && req_valid && !ref_due_q &&
                 req_op == WDC_OP_MASK_WRITE) begin
      data_pins_o <= req_mask; // R21 R22
      data_pins_oe <= 1'b1;
    end else if (st_q == WDC_ROW && op_q == WDC_OP_MASK_WRITE) begin
      data_pins_o <= mask_q; // R21 mask held past row fall
      data_pins_oe <= 1'b1;
    end else if ((st_q == WDC_COL || st_q == WDC_ACCESS) &&
                 op_q != WDC_OP_READ && op_q != WDC_OP_LATE_WRITE) begin
      data_pins_o <= wdata_q; // R5 R19
      data_pins_oe <= 1'b1;
    end else if (st_q == WDC_WRLATE) begin
      data_pins_o <= wdata_q; // R5
      data_pins_oe <= 1'b1;
    end else begin
      data_pins_oe <= 1'b0; // R10
    end
  end
  // ----------------------------------------
  // read capture at end of oe window, all 16 bits
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsp_rdata <= 16'h0000;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (st_q == WDC_OEREAD); // R18 R3
      if (st_q == WDC_OEREAD) begin
        rsp_rdata <= data_pins_i;
      end
    end
  end
endmodule : wdc_ctrl
`default_nettype wire

// file: rtl/wdc_defines.svh
// timing counts and field positions for the wide dram controller
`ifndef WDC_DEFINES_SVH
`define WDC_DEFINES_SVH
`define WDC_CLK_NS 40
`define WDC_ROW_LSB 8
`define WDC_ADDR_HALF 8
`define WDC_DATA_W 16
// strobe phase lengths in clock cycles (least times rounded up)
`define WDC_T_RP_NS 60
`define WDC_RP_CYC ((`WDC_T_RP_NS + `WDC_CLK_NS - 1) / `WDC_CLK_NS)
`define WDC_T_RCD_NS 25
`define WDC_RCD_CYC ((`WDC_T_RCD_NS + `WDC_CLK_NS - 1) / `WDC_CLK_NS)
`define WDC_T_CAS_NS 30
`define WDC_CAS_CYC ((`WDC_T_CAS_NS + `WDC_CLK_NS - 1) / `WDC_CLK_NS)
`define WDC_T_RAS_NS 100
`define WDC_RAS_CYC ((`WDC_T_RAS_NS + `WDC_CLK_NS - 1) / `WDC_CLK_NS)
`define WDC_T_CWD_NS 70
`define WDC_CWD_CYC ((`WDC_T_CWD_NS + `WDC_CLK_NS - 1) / `WDC_CLK_NS)
`define WDC_T_WP_NS 20
`define WDC_WP_CYC ((`WDC_T_WP_NS + `WDC_CLK_NS - 1) / `WDC_CLK_NS)
// refresh interval: one cycle every 125 us, longest time rounds down
`define WDC_T_REFI_NS 125000
`define WDC_REFI_CYC (`WDC_T_REFI_NS / `WDC_CLK_NS)
`define WDC_ROWS 256
`endif

// file: rtl/wdc_pkg.sv
// types for the wide dram controller
package wdc_pkg;
  typedef enum logic [1:0] {
    WDC_OP_READ, WDC_OP_EARLY_WRITE, WDC_OP_LATE_WRITE, WDC_OP_MASK_WRITE
  } wdc_op_type;
  typedef enum logic [3:0] {
    WDC_IDLE, WDC_ROW, WDC_COL, WDC_ACCESS, WDC_WRLATE, WDC_OEREAD,
    WDC_PRECH, WDC_CBR_CAS, WDC_CBR_RAS
  } wdc_state_type;
endpackage : wdc_pkg

// file: rtl/wdc_timer.sv
// down-counting phase timer with done flag
`timescale 1ns/1ps
`default_nettype none
module wdc_timer #(
  parameter int W = 12
) (
  input wire logic clk,         // system clock
  input wire logic rstn,        // async reset, active low
  input wire logic load,        // start a new count
  input wire logic [W-1:0] val, // cycles to wait
  output logic done             // count reached zero
);
  logic [W-1:0] cnt_q;
  // ----------------------------------------
  // counter
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  // plain zero test: load is fed back from done, so done must not read it
  assign done = (cnt_q == '0);
endmodule : wdc_timer
`default_nettype wire

// file: verif/wdc_dram_model.sv
// behavioural model of the wide dram device pins
`timescale 1ns/1ps
`default_nettype none
module wdc_dram_model (
  input wire logic ras_n, // row strobe, active low
  input wire logic cas_n, // column strobe, active low
  input wire logic wl_n, // lower lane write strobe
  input wire logic wh_n, // upper lane write strobe
  input wire logic oe_n, // output enable, active low
  input wire logic [7:0] addr, // shared address pins
  input wire logic [15:0] dq_in, // data pins as seen
  output logic [15:0] dq_out, // driven value, or inverse when floating
  output int refreshes // column-first refreshes seen
);
  logic [15:0] mem [0:65535];
  logic [15:0] mask;
  logic [15:0] word_a;
  logic [7:0] row;
  logic early;
  // blank array and counters
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    refreshes = 0;
    word_a = 16'h0000;
    early = 1'b0;
  end
  // write the enabled bits of the selected lanes
  task automatic put;
    logic [15:0] en;
    en = {{8{~wh_n}}, {8{~wl_n}}} & mask;
    mem[word_a] = (mem[word_a] & ~en) | (dq_in & en);
  endtask : put
  // row fall: refresh, or row half and fresh mask
  always @(negedge ras_n) begin
    #1;
    if (!cas_n) refreshes++;
    else begin
      row = addr;
      mask = (!wl_n && !wh_n) ? dq_in : 16'hFFFF;
    end
  end
  // column fall: column half, early write
  always @(negedge cas_n) begin
    #1;
    if (!ras_n) begin
      word_a = {row, addr};
      early = !wl_n || !wh_n;
      if (early) put();
    end
  end
  // strobe fall with column low: late write
  always @(negedge wl_n or negedge wh_n) begin
    #1;
    if (!ras_n && !cas_n && !early) put();
  end
  // drive only in an enabled read; float shows inverse pattern
  assign dq_out = (!ras_n && !cas_n && wl_n && wh_n && !oe_n) ?
    mem[word_a] : ~mem[word_a];
endmodule : wdc_dram_model
`default_nettype wire

// file: verif/wdc_ctrl_assertions.sv
// assertions on the wide dram controller pins
`timescale 1ns/1ps
`default_nettype none
module wdc_ctrl_assertions (
  input wire logic clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic req_valid, // request
  input wire logic req_ready, // request taken
  input wire logic [15:0] req_addr, // word address
  input wire logic row_strobe_n, // row strobe
  input wire logic col_strobe_n, // column strobe
  input wire logic low_lane_write_strobe_n, // lower write strobe
  input wire logic high_lane_write_strobe_n, // upper write strobe
  input wire logic out_enable_n, // output enable
  input wire logic [7:0] multiplexed_address_inputs, // address pins
  input wire logic data_pins_oe // host drives data
);
  localparam int REFI_MAX = 3225;
  logic [15:0] addr_q;
  logic [12:0] since_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // address of the last taken request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) addr_q <= 16'h0000;
    else if (req_valid && req_ready) addr_q <= req_addr;
  end
  // cycles since the last column-first refresh
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) since_q <= 13'h0000;
    else if ($fell(row_strobe_n) && !col_strobe_n) since_q <= 13'h0000;
    else since_q <= since_q + 13'h0001;
  end
  sequence s_row_open;
    $fell(row_strobe_n) && col_strobe_n;
  endsequence
  sequence s_col_open;
    $fell(col_strobe_n) && !row_strobe_n;
  endsequence
  sequence s_late_wr;
    !row_strobe_n && !col_strobe_n &&
      ($fell(low_lane_write_strobe_n) || $fell(high_lane_write_strobe_n));
  endsequence
  chk_row_address: assert property (s_row_open |->
    multiplexed_address_inputs == addr_q[15:8]) else $error("row half");
  chk_col_address: assert property (s_col_open |->
    multiplexed_address_inputs == addr_q[7:0]) else $error("col half");
  chk_early_setup: assert property (s_col_open ##0
    (!low_lane_write_strobe_n || !high_lane_write_strobe_n) |->
    $past(data_pins_oe)) else $error("early data late");
  chk_write_drive: assert property (!row_strobe_n && !col_strobe_n &&
    (!low_lane_write_strobe_n || !high_lane_write_strobe_n) |->
    data_pins_oe) else $error("write data absent");
  chk_late_oe: assert property (s_late_wr |-> out_enable_n)
    else $error("late write with oe low");
  chk_no_fight: assert property (!out_enable_n |-> !data_pins_oe)
    else $error("both sides drive");
  chk_read_lanes: assert property (!out_enable_n |->
    low_lane_write_strobe_n && high_lane_write_strobe_n)
    else $error("read with write strobe");
  chk_mask_row: assert property (s_row_open ##0
    !low_lane_write_strobe_n |-> !high_lane_write_strobe_n && data_pins_oe)
    else $error("mask select");
  chk_refresh_gap: assert property (since_q < REFI_MAX)
    else $error("refresh overdue");
endmodule : wdc_ctrl_assertions
bind wdc_ctrl wdc_ctrl_assertions i_wdc_ctrl_assertions (.clk(clk),
  .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
  .req_addr(req_addr), .row_strobe_n(row_strobe_n),
  .col_strobe_n(col_strobe_n),
  .low_lane_write_strobe_n(low_lane_write_strobe_n),
  .high_lane_write_strobe_n(high_lane_write_strobe_n),
  .out_enable_n(out_enable_n),
  .multiplexed_address_inputs(multiplexed_address_inputs),
  .data_pins_oe(data_pins_oe));
`default_nettype wire

// file: verif/wdc_ctrl_tb.sv
// self-checking bench for the wide dram controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module wdc_ctrl_tb import wdc_pkg::*;;
  logic clk = 0, rstn = 0, req_valid = 0, req_page = 0;
  wdc_op_type req_op = WDC_OP_READ;
  logic [15:0] req_addr = 0, req_wdata = 0, req_mask = 0;
  logic [1:0] req_lanes = 0;
  logic req_ready, rsp_valid, ras_n, cas_n, wl_n, wh_n, oe_n, dq_oe;
  logic [7:0] ma;
  logic [15:0] rsp_rdata, dq_o, dq_dev, dq_i;
  int err_count = 0, checked = 0, refreshes;
  // wire level: host when it drives, else device side
  assign dq_i = dq_oe ? dq_o : dq_dev;
  wdc_ctrl i_wdc_ctrl (.clk(clk), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_lanes(req_lanes), .req_mask(req_mask),
    .req_page(req_page), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .row_strobe_n(ras_n), .col_strobe_n(cas_n),
    .low_lane_write_strobe_n(wl_n), .high_lane_write_strobe_n(wh_n),
    .out_enable_n(oe_n), .multiplexed_address_inputs(ma),
    .data_pins_i(dq_i), .data_pins_o(dq_o), .data_pins_oe(dq_oe));
  wdc_dram_model i_wdc_dram_model (.ras_n(ras_n), .cas_n(cas_n),
    .wl_n(wl_n), .wh_n(wh_n), .oe_n(oe_n), .addr(ma), .dq_in(dq_i),
    .dq_out(dq_dev), .refreshes(refreshes));
  // clock
  initial forever #20 clk = ~clk;
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // hold a request until the edge that takes it
  task automatic issue(wdc_op_type op, logic [15:0] a, d, m,
                       logic [1:0] ln, logic pg);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_wdata <= d;
    req_mask <= m;
    req_lanes <= ln;
    req_page <= pg;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 300);
    if (n >= 300) begin
      err_count++;
      tally_and_finish();
    end
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : issue
  task automatic wr(wdc_op_type op, logic [15:0] a, d, logic [1:0] ln);
    issue(op, a, d, 16'hFFFF, ln, 1'b0);
  endtask : wr
  // read one word and compare
  task automatic rd(logic [15:0] a, e, string nm);
    int n;
    issue(WDC_OP_READ, a, 16'h0000, 16'h0000, 2'b00, 1'b0);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      err_count++;
      tally_and_finish();
    end
    `CHK(nm, e, rsp_rdata)
  endtask : rd
  task automatic t_reset;
    `CHK("idle strobes", 4'hF, {ras_n, cas_n, wl_n, wh_n})
    `CHK("idle drive", 1'b0, dq_oe)
  endtask : t_reset
  task automatic t_lanes;
    wr(WDC_OP_EARLY_WRITE, 16'h1234, 16'hA5C3, 2'b11);
    rd(16'h1234, 16'hA5C3, "word");
    wr(WDC_OP_EARLY_WRITE, 16'h2345, 16'hAABB, 2'b01);
    rd(16'h2345, 16'h00BB, "low lane");
    wr(WDC_OP_EARLY_WRITE, 16'h2345, 16'hCCDD, 2'b10);
    rd(16'h2345, 16'hCCBB, "high lane");
  endtask : t_lanes
  task automatic t_late;
    wr(WDC_OP_LATE_WRITE, 16'h00FF, 16'h5A5A, 2'b11);
    wr(WDC_OP_LATE_WRITE, 16'h0100, 16'h3C3C, 2'b11);
    rd(16'h00FF, 16'h5A5A, "late a");
    rd(16'h0100, 16'h3C3C, "late b");
  endtask : t_late
  task automatic t_mask;
    wr(WDC_OP_EARLY_WRITE, 16'h8001, 16'h0F0F, 2'b11);
    issue(WDC_OP_MASK_WRITE, 16'h8001, 16'hFFFF, 16'h00F0, 2'b11, 1'b0);
    rd(16'h8001, 16'h0FFF, "mask a");
    issue(WDC_OP_MASK_WRITE, 16'h8001, 16'h0000, 16'h0F00, 2'b11, 1'b0);
    rd(16'h8001, 16'h00FF, "mask b");
  endtask : t_mask
  task automatic t_page;
    issue(WDC_OP_EARLY_WRITE, 16'h4410, 16'hBEEF, 16'hFFFF, 2'b11, 1'b1);
    issue(WDC_OP_EARLY_WRITE, 16'h4411, 16'hCAFE, 16'hFFFF, 2'b11, 1'b0);
    rd(16'h4410, 16'hBEEF, "page a");
    rd(16'h4411, 16'hCAFE, "page b");
  endtask : t_page
  task automatic t_refresh;
    repeat (3300) @(posedge clk);
    `CHK("refresh seen", 1'b1, refreshes > 0)
    rd(16'h1234, 16'hA5C3, "kept");
  endtask : t_refresh
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    t_reset();
    rstn <= 1'b1;
    t_lanes();
    t_late();
    t_mask();
    t_page();
    t_refresh();
    tally_and_finish();
  end
endmodule : wdc_ctrl_tb
`default_nettype wire
